/* File: hw/iod_pkg.sv */
// constants, field masks and carrier types for the low i/o register decoder
// Function
// R1: software writes zero into reserved bit positions of any register it writes
// R2: software never writes to a reserved i/o location
// R3: locations 0x00-0x1F accept single-bit set and clear operations
// R4: locations 0x00-0x1F support skip-if-bit-set and skip-if-bit-clear tests
// R5: writing one clears a status flag; writing zero leaves it unchanged
// R6: single-bit operations touch only the addressed bit, never other flags
// R7: short i/o instructions reach the 64 registers at i/o addresses 0x00-0x3F
// R8: data-space accesses reach each i/o register at its address plus 0x20
// R9: extended space 0x60-0xFF is data-space only, short i/o cannot reach it
// R10: nvm address high byte exists only on larger-memory variants
// R11: reserved locations and bits read zero, with no side effects
// R12: every register is eight bits and completes in one access cycle
`default_nettype none
package iod_pkg;

  localparam int IO_LOCS = 64;
  localparam logic [7:0] IO_LAST = 8'h3F;
  localparam logic [7:0] BIT_LAST = 8'h1F;
  localparam logic [7:0] DATA_OFS = 8'h20;
  localparam logic [7:0] EXT_FIRST = 8'h60;
  localparam logic [7:0] RESET_VAL = 8'h00;

  // i/o offsets
  localparam logic [5:0] A_PIN_B = 6'h03;
  localparam logic [5:0] A_DIR_B = 6'h04;
  localparam logic [5:0] A_OUT_B = 6'h05;
  localparam logic [5:0] A_PIN_C = 6'h06;
  localparam logic [5:0] A_DIR_C = 6'h07;
  localparam logic [5:0] A_OUT_C = 6'h08;
  localparam logic [5:0] A_PIN_D = 6'h09;
  localparam logic [5:0] A_DIR_D = 6'h0A;
  localparam logic [5:0] A_OUT_D = 6'h0B;
  localparam logic [5:0] A_T0_FLG = 6'h15;
  localparam logic [5:0] A_T1_FLG = 6'h16;
  localparam logic [5:0] A_T2_FLG = 6'h17;
  localparam logic [5:0] A_PC_FLG = 6'h1B;
  localparam logic [5:0] A_EI_FLG = 6'h1C;
  localparam logic [5:0] A_EI_MSK = 6'h1D;
  localparam logic [5:0] A_SCR0 = 6'h1E;
  localparam logic [5:0] A_NVM_CTL = 6'h1F;
  localparam logic [5:0] A_NVM_DAT = 6'h20;
  localparam logic [5:0] A_NVM_AL = 6'h21;
  localparam logic [5:0] A_NVM_AH = 6'h22;
  localparam logic [5:0] A_PRESC = 6'h23;
  localparam logic [5:0] A_T0_CA = 6'h24;
  localparam logic [5:0] A_T0_CB = 6'h25;
  localparam logic [5:0] A_T0_CNT = 6'h26;
  localparam logic [5:0] A_T0_CMPA = 6'h27;
  localparam logic [5:0] A_T0_CMPB = 6'h28;
  localparam logic [5:0] A_SCR1 = 6'h2A;
  localparam logic [5:0] A_SCR2 = 6'h2B;
  localparam logic [5:0] A_SP_CTL = 6'h2C;
  localparam logic [5:0] A_SP_STA = 6'h2D;
  localparam logic [5:0] A_SP_DAT = 6'h2E;
  localparam logic [5:0] A_CMP = 6'h30;
  localparam logic [5:0] A_SLEEP = 6'h33;
  localparam logic [5:0] A_RST_CAUSE = 6'h34;
  localparam logic [5:0] A_MISC = 6'h35;

  // implemented-bit masks: the full mask, and masks where fewer than eight bits exist
  localparam logic [7:0] M_FULL = 8'hFF;
  localparam logic [7:0] M_PORT_C = 8'h7F;
  localparam logic [7:0] M_T0_FLG = 8'h07;
  localparam logic [7:0] M_T1_FLG = 8'h27;
  localparam logic [7:0] M_T2_FLG = 8'h07;
  localparam logic [7:0] M_PC_FLG = 8'h07;
  localparam logic [7:0] M_EI = 8'h03;
  localparam logic [7:0] M_NVM_CTL = 8'h3F;
  localparam logic [7:0] M_PRESC = 8'h83;
  localparam logic [7:0] M_T0_CA = 8'hF3;
  localparam logic [7:0] M_T0_CB = 8'hCF;
  localparam logic [7:0] M_SP_STA = 8'hC1;
  localparam logic [7:0] M_SLEEP = 8'h0F;
  localparam logic [7:0] M_RST_CAUSE = 8'h0F;
  localparam logic [7:0] M_MISC = 8'h13;
  // live status bits and the comparator event flag
  localparam logic [7:0] M_SP_LIVE = 8'hC0;
  localparam logic [7:0] M_CMP_LIVE = 8'h20;
  localparam logic [7:0] M_CMP_FLG = 8'h10;

  typedef enum logic [2:0] {
    OP_IO_READ = 3'b000,
    OP_IO_WRITE = 3'b001,
    OP_DATA_READ = 3'b010,
    OP_DATA_WRITE = 3'b011,
    OP_BIT_SET = 3'b100,
    OP_BIT_CLEAR = 3'b101,
    OP_SKIP_SET = 3'b110,
    OP_SKIP_CLEAR = 3'b111
  } iod_op_type;

  typedef struct packed {
    logic valid;
    iod_op_type op;
    logic [7:0] addr;
    logic [2:0] bit_sel;
    logic [7:0] wdata;
  } iod_req_type;

  typedef struct packed {
    logic ack;
    logic hit;
    logic skip;
    logic [7:0] rdata;
  } iod_resp_type;

  typedef struct packed {
    logic [7:0] pb;
    logic [7:0] pc;
    logic [7:0] pd;
  } iod_pins_type;

  typedef struct packed {
    logic [7:0] timer0;
    logic [7:0] timer1;
    logic [7:0] timer2;
    logic [7:0] pin_change;
    logic [7:0] ext_irq;
    logic comparator;
  } iod_event_type;

  typedef struct packed {
    logic spi_done;
    logic spi_collision;
    logic comp_out;
  } iod_status_type;

endpackage : iod_pkg
`default_nettype wire

/* File: hw/iod_decoder.sv */
// low i/o space decoder with register storage, pin sampling and flag handling
`timescale 1ns/100ps
`default_nettype none
module iod_decoder
  import iod_pkg::*;
#(
  parameter bit HAS_NVM_ADDR_HIGH = 1'b1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire iod_req_type req,
  output iod_resp_type resp,
  input wire iod_pins_type pins,
  input wire iod_status_type status,
  input wire iod_event_type events,
  output logic [IO_LOCS-1:0][7:0] reg_image
);

  logic [IO_LOCS-1:0][7:0] store_reg;
  logic [IO_LOCS-1:0][7:0] store_next;
  logic [23:0] sync1_reg;
  logic [23:0] sync2_reg;
  logic [23:0] sync3_reg;
  logic [23:0] pin_val_reg;
  logic [23:0] agree;
  logic dec_hit;
  logic [5:0] dec_idx;
  logic dec_wr;
  logic dec_rd;
  logic dec_skip;
  logic [7:0] dec_bits;
  logic [7:0] dec_val;
  logic [7:0] rd_val;
  logic [7:0] rw_bits;
  logic [7:0] clr_bits;

  // bits that exist at a location; everything else reads zero
  function automatic logic [7:0] impl_mask(input logic [5:0] a);
    case (a)
      A_PIN_B, A_DIR_B, A_OUT_B, A_PIN_D, A_DIR_D, A_OUT_D: impl_mask = M_FULL;
      A_PIN_C, A_DIR_C, A_OUT_C: impl_mask = M_PORT_C;
      A_T0_FLG: impl_mask = M_T0_FLG;
      A_T1_FLG: impl_mask = M_T1_FLG;
      A_T2_FLG: impl_mask = M_T2_FLG;
      A_PC_FLG: impl_mask = M_PC_FLG;
      A_EI_FLG, A_EI_MSK: impl_mask = M_EI;
      A_NVM_CTL: impl_mask = M_NVM_CTL;
      A_PRESC: impl_mask = M_PRESC;
      A_T0_CA: impl_mask = M_T0_CA;
      A_T0_CB: impl_mask = M_T0_CB;
      A_SP_STA: impl_mask = M_SP_STA;
      A_SLEEP: impl_mask = M_SLEEP;
      A_RST_CAUSE: impl_mask = M_RST_CAUSE;
      A_MISC: impl_mask = M_MISC;
      A_SCR0, A_SCR1, A_SCR2, A_NVM_DAT, A_NVM_AL, A_NVM_AH, A_T0_CNT,
      A_T0_CMPA, A_T0_CMPB, A_SP_CTL, A_SP_DAT, A_CMP: impl_mask = M_FULL;
      default: impl_mask = 8'h00;
    endcase
  endfunction : impl_mask

  // write-one-to-clear flag bits
  function automatic logic [7:0] w1c_mask(input logic [5:0] a);
    case (a)
      A_T0_FLG: w1c_mask = M_T0_FLG;
      A_T1_FLG: w1c_mask = M_T1_FLG;
      A_T2_FLG: w1c_mask = M_T2_FLG;
      A_PC_FLG: w1c_mask = M_PC_FLG;
      A_EI_FLG: w1c_mask = M_EI;
      A_CMP: w1c_mask = M_CMP_FLG;
      default: w1c_mask = 8'h00;
    endcase
  endfunction : w1c_mask

  // bits that show live state and ignore writes
  function automatic logic [7:0] ro_mask(input logic [5:0] a);
    case (a)
      A_PIN_B, A_PIN_D: ro_mask = M_FULL;
      A_PIN_C: ro_mask = M_PORT_C;
      A_SP_STA: ro_mask = M_SP_LIVE;
      A_CMP: ro_mask = M_CMP_LIVE;
      default: ro_mask = 8'h00;
    endcase
  endfunction : ro_mask

  // size of the nvm address high byte depends on the variant
  function automatic logic [7:0] eff_impl(input logic [5:0] a);
    if (a == A_NVM_AH && !HAS_NVM_ADDR_HIGH) begin // R10
      eff_impl = 8'h00;
    end else begin
      eff_impl = impl_mask(a);
    end
  endfunction : eff_impl

  // hardware flag sources aligned to their flag positions
  function automatic logic [7:0] event_bits(input logic [5:0] a, input iod_event_type e);
    case (a)
      A_T0_FLG: event_bits = e.timer0 & M_T0_FLG;
      A_T1_FLG: event_bits = e.timer1 & M_T1_FLG;
      A_T2_FLG: event_bits = e.timer2 & M_T2_FLG;
      A_PC_FLG: event_bits = e.pin_change & M_PC_FLG;
      A_EI_FLG: event_bits = e.ext_irq & M_EI;
      A_CMP: event_bits = e.comparator ? M_CMP_FLG : 8'h00;
      default: event_bits = 8'h00;
    endcase
  endfunction : event_bits

  // pins come from outside: three stages, accept a bit once stages two and three agree
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync1_reg <= 24'h000000;
      sync2_reg <= 24'h000000;
      sync3_reg <= 24'h000000;
    end else begin
      sync1_reg <= pins;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  assign agree = ~(sync2_reg ^ sync3_reg);

  // filtered pin state; a bit holds its old value while it is still settling
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pin_val_reg <= 24'h000000;
    end else begin
      pin_val_reg <= (pin_val_reg & ~agree) | (sync3_reg & agree);
    end
  end

  // live value of read-only bits at a location
  function automatic logic [7:0] live_bits(input logic [5:0] a, input logic [23:0] p,
                                           input iod_status_type s);
    case (a)
      A_PIN_B: live_bits = p[23:16];
      A_PIN_C: live_bits = p[15:8] & M_PORT_C;
      A_PIN_D: live_bits = p[7:0];
      A_SP_STA: live_bits = {s.spi_done, s.spi_collision, 6'h00};
      A_CMP: live_bits = {2'b00, s.comp_out, 5'h00};
      default: live_bits = 8'h00;
    endcase
  endfunction : live_bits

  // address decode per access kind
  always_comb begin
    dec_hit = 1'b0;
    dec_idx = req.addr[5:0];
    dec_wr = 1'b0;
    dec_rd = 1'b0;
    dec_skip = 1'b0;
    dec_bits = M_FULL;
    dec_val = req.wdata;
    case (req.op)
      OP_IO_READ, OP_IO_WRITE: begin
        dec_hit = req.addr <= IO_LAST; // R7
        dec_wr = req.op == OP_IO_WRITE;
        dec_rd = req.op == OP_IO_READ;
      end
      OP_DATA_READ, OP_DATA_WRITE: begin
        // extended space above the window belongs to another decoder
        dec_hit = req.addr >= DATA_OFS && req.addr < EXT_FIRST; // R9
        dec_idx = 6'(req.addr - DATA_OFS); // R8
        dec_wr = req.op == OP_DATA_WRITE;
        dec_rd = req.op == OP_DATA_READ;
      end
      OP_BIT_SET, OP_BIT_CLEAR: begin
        dec_hit = req.addr <= BIT_LAST; // R3
        dec_wr = 1'b1;
        dec_bits = 8'(8'h01 << req.bit_sel); // R6
        dec_val = (req.op == OP_BIT_SET) ? M_FULL : 8'h00;
      end
      OP_SKIP_SET, OP_SKIP_CLEAR: begin
        dec_hit = req.addr <= BIT_LAST; // R4
        dec_skip = 1'b1;
      end
      default: begin
        dec_hit = 1'b0;
      end
    endcase
    dec_hit = dec_hit && req.valid;
  end

  // read view: stored bits, live bits, zero elsewhere
  assign rd_val = ((store_reg[dec_idx] & ~ro_mask(dec_idx)) | live_bits(dec_idx, pin_val_reg,
                  status)) & eff_impl(dec_idx); // R11

  // bits that a write of this request may touch
  assign rw_bits = dec_bits & eff_impl(dec_idx) & ~ro_mask(dec_idx) & ~w1c_mask(dec_idx);
  assign clr_bits = dec_bits & w1c_mask(dec_idx) & dec_val; // R5

  // next storage value; hardware set beats a same-cycle software clear
  always_comb begin
    for (int i = 0; i < IO_LOCS; i++) begin
      store_next[i] = store_reg[i];
      if (dec_hit && dec_wr && dec_idx == 6'(i)) begin
        store_next[i] = (store_reg[i] & ~rw_bits) | (dec_val & rw_bits); // R12
        store_next[i] = store_next[i] & ~clr_bits; // R5 R6
      end
      store_next[i] = store_next[i] | event_bits(6'(i), events); // R5
      store_next[i] = store_next[i] & eff_impl(6'(i)) & ~ro_mask(6'(i)); // R10 R11
    end
  end

  // register storage, all zero out of reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      store_reg <= {IO_LOCS{RESET_VAL}};
    end else begin
      store_reg <= store_next;
    end
  end

  assign reg_image = store_reg;

  // answer one cycle after the request; misses read zero
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      resp <= '0;
    end else begin
      resp.ack <= req.valid; // R12
      resp.hit <= dec_hit;
      resp.rdata <= (dec_hit && dec_rd) ? rd_val : 8'h00; // R11
      resp.skip <= dec_hit && dec_skip &&
                   (rd_val[req.bit_sel] == (req.op == OP_SKIP_SET)); // R4
    end
  end

  // helper state for the checks below
  logic [5:0] q_idx_reg;
  logic [2:0] q_bit_reg;
  logic [7:0] q_old_reg;
  logic q_sel_reg;
  logic [7:0] q_ev_reg;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      q_idx_reg <= 6'h00;
      q_bit_reg <= 3'h0;
      q_old_reg <= 8'h00;
      q_sel_reg <= 1'b0;
      q_ev_reg <= 8'h00;
    end else begin
      q_idx_reg <= dec_idx;
      q_bit_reg <= req.bit_sel;
      q_old_reg <= store_reg[dec_idx];
      q_sel_reg <= rd_val[req.bit_sel];
      q_ev_reg <= event_bits(dec_idx, events);
    end
  end

  // bit set lands on a plain writable bit
  property p_bit_set;
    @(posedge clk) disable iff (!nrst)
    (dec_hit && req.op == OP_BIT_SET && rw_bits != 8'h00) |=>
      store_reg[q_idx_reg][q_bit_reg];
  endproperty
  a_bit_set: assert property (p_bit_set) else $error("bit set did not set"); // R3

  // bit clear lands on a plain writable bit
  property p_bit_clear;
    @(posedge clk) disable iff (!nrst)
    (dec_hit && req.op == OP_BIT_CLEAR && rw_bits != 8'h00) |=>
      !store_reg[q_idx_reg][q_bit_reg];
  endproperty
  a_bit_clear: assert property (p_bit_clear) else $error("bit clear did not clear"); // R3

  // skip answer matches the sampled bit and polarity
  property p_skip;
    @(posedge clk) disable iff (!nrst)
    (dec_hit && dec_skip) |=> resp.ack && resp.hit &&
      (resp.skip == (q_sel_reg == ($past(req.op) == OP_SKIP_SET)));
  endproperty
  a_skip: assert property (p_skip) else $error("skip answer wrong"); // R4

  // a one written to a flag clears it unless an event sets it again
  property p_w1c;
    @(posedge clk) disable iff (!nrst)
    (dec_hit && dec_wr && clr_bits != 8'h00) |=>
      ((store_reg[q_idx_reg] & $past(clr_bits) & ~q_ev_reg) == 8'h00);
  endproperty
  a_w1c: assert property (p_w1c) else $error("flag not cleared by one"); // R5

  // a bit operation never drops a flag outside the addressed bit
  property p_bit_only;
    @(posedge clk) disable iff (!nrst)
    (dec_hit && (req.op == OP_BIT_SET || req.op == OP_BIT_CLEAR)) |=>
      ((q_old_reg & ~(8'(8'h01 << q_bit_reg)) & ~store_reg[q_idx_reg]) == 8'h00);
  endproperty
  a_bit_only: assert property (p_bit_only) else $error("neighbour bit lost"); // R6

  // data-space alias window answers as a hit
  property p_alias;
    @(posedge clk) disable iff (!nrst)
    (req.valid && (req.op == OP_DATA_READ || req.op == OP_DATA_WRITE) &&
     req.addr >= DATA_OFS && req.addr < EXT_FIRST) |=> resp.hit;
  endproperty
  a_alias: assert property (p_alias) else $error("alias window missed"); // R8

  // extended data space is not decoded here
  property p_ext;
    @(posedge clk) disable iff (!nrst)
    (req.valid && req.addr >= EXT_FIRST) |=> resp.ack && !resp.hit && resp.rdata == 8'h00;
  endproperty
  a_ext: assert property (p_ext) else $error("extended space decoded"); // R9

  // reserved locations read zero
  property p_reserved;
    @(posedge clk) disable iff (!nrst)
    (dec_hit && dec_rd && impl_mask(dec_idx) == 8'h00) |=> resp.rdata == 8'h00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved read not zero"); // R11

  // every request answered in the next cycle, nothing else
  property p_one_cycle;
    @(posedge clk) disable iff (!nrst)
    req.valid |=> resp.ack ##1 (resp.ack == $past(req.valid));
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("answer not one cycle"); // R12

  // small variant keeps the high address byte empty
  property p_no_high;
    @(posedge clk) disable iff (!nrst)
    !HAS_NVM_ADDR_HIGH |-> store_reg[A_NVM_AH] == 8'h00;
  endproperty
  a_no_high: assert property (p_no_high) else $error("high byte present"); // R10

  // an event in the clearing cycle keeps its flag set
  property p_set_wins;
    @(posedge clk) disable iff (!nrst)
    (dec_hit && dec_wr && (clr_bits & event_bits(dec_idx, events)) != 8'h00) |=>
      ((store_reg[q_idx_reg] & q_ev_reg) == q_ev_reg);
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost to a clear"); // R5

  // a write with no ones on the flags leaves every flag standing
  property p_zero_keeps;
    @(posedge clk) disable iff (!nrst)
    (dec_hit && dec_wr && clr_bits == 8'h00) |=>
      ((q_old_reg & w1c_mask(q_idx_reg) & ~store_reg[q_idx_reg]) == 8'h00);
  endproperty
  a_zero_keeps: assert property (p_zero_keeps) else $error("flag lost on zero write"); // R5

  // short i/o accesses inside the 64-location window are decoded here
  property p_io_range;
    @(posedge clk) disable iff (!nrst)
    (req.valid && (req.op == OP_IO_READ || req.op == OP_IO_WRITE) &&
     req.addr <= IO_LAST) |=> resp.hit;
  endproperty
  a_io_range: assert property (p_io_range) else $error("io window missed"); // R7

  // a refused request leaves storage alone
  property p_miss_quiet;
    @(posedge clk) disable iff (!nrst)
    (req.valid && !dec_hit && events == '0) |=> store_reg == $past(store_reg);
  endproperty
  a_miss_quiet: assert property (p_miss_quiet) else $error("refused request changed state"); // R11

  // no answer without a request
  property p_idle;
    @(posedge clk) disable iff (!nrst)
    !req.valid |=> !resp.ack;
  endproperty
  a_idle: assert property (p_idle) else $error("answer without request"); // R12

  // main scenarios
  c_flag_bit_set: cover property (@(posedge clk) disable iff (!nrst)
    dec_hit && req.op == OP_BIT_SET && w1c_mask(dec_idx) != 8'h00);
  c_skip_taken: cover property (@(posedge clk) disable iff (!nrst)
    resp.skip);
  c_alias_read: cover property (@(posedge clk) disable iff (!nrst)
    dec_hit && req.op == OP_DATA_READ && impl_mask(dec_idx) != 8'h00);
  c_set_over_clear: cover property (@(posedge clk) disable iff (!nrst)
    clr_bits != 8'h00 && (clr_bits & event_bits(dec_idx, events)) != 8'h00);
  c_refused: cover property (@(posedge clk) disable iff (!nrst)
    req.valid && !dec_hit);

endmodule : iod_decoder
`default_nettype wire

/* File: verification/iod_core_model.sv */
// behavioural core model issuing i/o, data-space and single-bit accesses
`timescale 1ns/100ps
`default_nettype none
module iod_core_model
  import iod_pkg::*;
(
  input wire logic clk,
  input wire iod_resp_type resp,
  output var iod_req_type req
);

  // idle request from time zero, so nothing is taken during reset
  initial req = '0;

  // i/o indices that hold no register and must never be written, apart from 0x37 and 0x3D-0x3F, which are not listed
  function automatic bit is_rsvd(input logic [5:0] a);
    return a inside {[6'h00:6'h02], [6'h0C:6'h14], [6'h18:6'h1A], 6'h29, 6'h2F,
                     6'h31, 6'h32, 6'h36, [6'h38:6'h3C]};
  endfunction : is_rsvd

  // one access: request held from one edge to the taking edge, answer read mid-cycle
  task automatic access(input iod_op_type op, input logic [7:0] a, input logic [2:0] b,
                        input logic [7:0] wd, output iod_resp_type r);
    logic [5:0] idx;
    idx = (op == OP_DATA_WRITE) ? 6'(a - DATA_OFS) : a[5:0];
    // an i/o or data-space write to a listed empty location is dropped here, never sent
    if ((op == OP_IO_WRITE || op == OP_DATA_WRITE) && is_rsvd(idx)) begin
      r = '0;
      return;
    end
    @(posedge clk);
    req <= '{valid: 1'b1, op: op, addr: a, bit_sel: b, wdata: wd};
    @(posedge clk);
    req <= '0;
    @(negedge clk);
    r = resp;
  endtask : access

endmodule : iod_core_model
`default_nettype wire

/* File: verification/iod_decoder_tb.sv */
// self-checking bench for the low i/o space decoder
`timescale 1ns/100ps
`default_nettype none
module iod_decoder_tb;
  import iod_pkg::*;

  logic clk = 1'b0;
  logic nrst = 1'b0;
  iod_req_type req;
  iod_resp_type resp;
  iod_resp_type resp_small;
  iod_resp_type r;
  iod_pins_type pins = '0;
  iod_status_type status = '0;
  iod_event_type events = '0;
  logic [IO_LOCS-1:0][7:0] image;
  int n_fail = 0;
  int cmp_count = 0;

  // 10 MHz core clock
  always #50 clk = ~clk;

  iod_decoder iod_decoder_inst (.clk(clk), .nrst(nrst), .req(req), .resp(resp),
    .pins(pins), .status(status), .events(events), .reg_image(image));

  // smallest variant, same requests, only its read data is looked at
  iod_decoder #(.HAS_NVM_ADDR_HIGH(1'b0)) iod_decoder_lite_inst (.clk(clk), .nrst(nrst),
    .req(req), .resp(resp_small), .pins(pins), .status(status), .events(events),
    .reg_image());

  iod_core_model iod_core_model_inst (.clk(clk), .resp(resp), .req(req));

  task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_byte

  task automatic chk_bit(input string what, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit

  task automatic acc(input iod_op_type op, input logic [7:0] a, input logic [2:0] b,
                     input logic [7:0] wd);
    iod_core_model_inst.access(op, a, b, wd, r);
  endtask : acc

  task automatic rd(input iod_op_type op, input logic [7:0] a, input logic [7:0] exp);
    acc(op, a, 3'h0, 8'h00);
    chk_byte($sformatf("read %h", a), exp, r.rdata);
  endtask : rd

  // direct and aliased accesses, written values have no reserved bits set
  task automatic t_rw();
    acc(OP_IO_WRITE, 8'h05, 3'h0, 8'hA5);
    chk_bit("write ack", 1'b1, r.ack);
    chk_byte("image 05", 8'hA5, image[5]);
    rd(OP_IO_READ, 8'h05, 8'hA5);
    rd(OP_DATA_READ, 8'h25, 8'hA5);
    acc(OP_DATA_WRITE, 8'h4B, 3'h0, 8'h3C);
    rd(OP_IO_READ, 8'h2B, 8'h3C);
  endtask : t_rw

  // upper range edges of each access kind and an empty location
  task automatic t_refuse();
    acc(OP_IO_READ, 8'h3F, 3'h0, 8'h00);
    chk_bit("hit io 3F", 1'b1, r.hit);
    acc(OP_IO_READ, 8'h40, 3'h0, 8'h00);
    chk_bit("hit io 40", 1'b0, r.hit);
    acc(OP_DATA_READ, 8'h5F, 3'h0, 8'h00);
    chk_bit("hit data 5F", 1'b1, r.hit);
    acc(OP_DATA_READ, 8'h60, 3'h0, 8'h00);
    chk_bit("hit data 60", 1'b0, r.hit);
    acc(OP_BIT_SET, 8'h20, 3'h0, 8'h00);
    chk_bit("hit bit set 20", 1'b0, r.hit);
    acc(OP_SKIP_SET, 8'h20, 3'h0, 8'h00);
    chk_bit("hit skip 20", 1'b0, r.hit);
    rd(OP_IO_READ, 8'h0C, 8'h00);
    rd(OP_IO_READ, 8'h05, 8'hA5);
  endtask : t_refuse

  // set, test and clear one bit of the scratch register
  task automatic t_bits();
    acc(OP_BIT_SET, 8'h1E, 3'h7, 8'h00);
    rd(OP_IO_READ, 8'h1E, 8'h80);
    acc(OP_SKIP_SET, 8'h1E, 3'h7, 8'h00);
    chk_bit("skip set bit7", 1'b1, r.skip);
    acc(OP_SKIP_CLEAR, 8'h1E, 3'h7, 8'h00);
    chk_bit("skip clear bit7", 1'b0, r.skip);
    acc(OP_SKIP_CLEAR, 8'h1E, 3'h6, 8'h00);
    chk_bit("skip clear bit6", 1'b1, r.skip);
    acc(OP_BIT_CLEAR, 8'h1E, 3'h7, 8'h00);
    rd(OP_IO_READ, 8'h1E, 8'h00);
  endtask : t_bits

  // flags raised by a one-cycle event, then cleared by ones only
  task automatic t_flags();
    @(posedge clk);
    events.timer0 <= 8'h07;
    @(posedge clk);
    events.timer0 <= 8'h00;
    rd(OP_IO_READ, 8'h15, 8'h07);
    acc(OP_IO_WRITE, 8'h15, 3'h0, 8'h02);
    rd(OP_IO_READ, 8'h15, 8'h05);
    acc(OP_IO_WRITE, 8'h15, 3'h0, 8'h00);
    rd(OP_IO_READ, 8'h15, 8'h05);
    acc(OP_BIT_SET, 8'h15, 3'h0, 8'h00);
    rd(OP_IO_READ, 8'h15, 8'h04);
    acc(OP_BIT_CLEAR, 8'h15, 3'h2, 8'h00);
    rd(OP_IO_READ, 8'h15, 8'h04);
    // comparator event held through a clearing write: the set must win
    @(posedge clk);
    events.comparator <= 1'b1;
    acc(OP_IO_WRITE, 8'h30, 3'h0, 8'h10);
    rd(OP_IO_READ, 8'h30, 8'h10);
    @(posedge clk);
    events.comparator <= 1'b0;
    acc(OP_IO_WRITE, 8'h30, 3'h0, 8'h10);
    rd(OP_IO_READ, 8'h30, 8'h00);
  endtask : t_flags

  // pin levels after the synchroniser, and live status bits
  task automatic t_pins();
    @(posedge clk);
    pins <= '{pb: 8'h5A, pc: 8'h00, pd: 8'hC3};
    status <= '{spi_done: 1'b1, spi_collision: 1'b0, comp_out: 1'b1};
    repeat (4) @(posedge clk);
    rd(OP_IO_READ, 8'h03, 8'h5A);
    rd(OP_DATA_READ, 8'h29, 8'hC3);
    acc(OP_SKIP_CLEAR, 8'h03, 3'h0, 8'h00);
    chk_bit("skip pin bit0", 1'b1, r.skip);
    rd(OP_IO_READ, 8'h30, 8'h20);
    rd(OP_IO_READ, 8'h2D, 8'h80);
  endtask : t_pins

  // the high address byte lives only in the larger variant
  task automatic t_nvm();
    acc(OP_IO_WRITE, 8'h22, 3'h0, 8'h81);
    rd(OP_IO_READ, 8'h22, 8'h81);
    chk_byte("small variant 22", 8'h00, resp_small.rdata);
  endtask : t_nvm

  task automatic conclude();
    if (n_fail == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : conclude

  // main sequence after six cycles of reset
  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    t_rw();
    t_refuse();
    t_bits();
    t_flags();
    t_pins();
    t_nvm();
    conclude();
  end

  // watchdog, well beyond the hundred or so cycles the tests take
  initial begin
    #(100 * 2000);
    n_fail++;
    conclude();
  end

endmodule : iod_decoder_tb
`default_nettype wire
